//--- tci_defines.svh
// Register offsets, field positions, codes and timing figures of the thermocouple input block.
`ifndef TCI_DEFINES_SVH
`define TCI_DEFINES_SVH
// ==========================================================================
// Register map, word index on the register port.
`define TCI_REG_CHAN_FMT  4'h0
`define TCI_REG_PTR       4'h1
`define TCI_REG_TYPE      4'h3
`define TCI_REG_UNITS     4'h4
`define TCI_REG_OSD_EN    4'h5
`define TCI_REG_OSD_FILL  4'h6
`define TCI_REG_DIAG      4'h7
// ==========================================================================
// Field positions and legal ranges.
`define TCI_FMT_BIN_BIT   15
`define TCI_CH_CNT_HI     11
`define TCI_CH_CNT_LO     8
`define TCI_CH_CNT_MIN    4'h1
`define TCI_CH_CNT_MAX    4'h4
`define TCI_FMT_PAD_MASK  16'h70ff
`define TCI_SCALE_BIT     0
`define TCI_TWOS_BIT      1
`define TCI_UNITS_LAST    16'h0003
`define TCI_OSD_BIT       0
`define TCI_FILL_BIT      0
// ==========================================================================
// Sensor type codes.
`define TCI_TYPE_R        16'h0003
`define TCI_TYPE_S        16'h0004
`define TCI_TYPE_B        16'h0006
`define TCI_TYPE_C        16'h0008
`define TCI_TYPE_LAST_TC  16'h0008
`define TCI_TYPE_MV39_BI  16'h000a
`define TCI_TYPE_MV78_BI  16'h000b
`define TCI_TYPE_MV156_BI 16'h000d
`define TCI_TYPE_LAST     16'h000e
// ==========================================================================
// Result values.
`define TCI_UP_UNI        16'hffff
`define TCI_UP_BI         16'h7fff
`define TCI_DOWN          16'h0000
`define TCI_SIGN_MASK     16'h8000
`define TCI_PAIR_STRIDE   16'h0002
`define TCI_SECOND_WORD   16'h0001
`define TCI_RESET_WORD    16'h0000
// ==========================================================================
// Timing.
`define TCI_CONV_MS       270
`define TCI_CLK_KHZ       10000
`endif

//--- tci_pkg.sv
// Types shared by the thermocouple input block.
`default_nettype none
package tci_pkg;
   typedef enum logic [1:0] {
      TCI_IDLE,
      TCI_CONV,
      TCI_SECOND
   } tci_state_t;
endpackage
`default_nettype wire

//--- tci_input_config.sv
// Thermocouple input configuration, scan sequencer and result formatter.
`timescale 1ns/1ps
`default_nettype none
`include "tci_defines.svh"

// Operation
// - Channel n result at base plus 2(n-1)
// - Binary result written to first word only
// - Codes 0..8 select J,K,E,R,S,T,B,N,C
// - Codes 9..E select six voltage ranges
// - Voltage types switch cold junction compensation off
// - Thermocouple results in tenths of degrees
// - Bipolar types clamp 3276.7, positive-only 6553.5
// - Negative result sets most significant bit
// - Positive-only types ignore the sign format
// - Bipolar voltage: magnitude-sign or two's complement
// - Units bit 0 picks scale, ignored for voltage
// - Units bit 1 picks sign format, codes 0..3
// - Open-sensor detect enabled when bit 0 clear, thermocouple types only
// - Up-scale fill FFFF unipolar, 7FFF bipolar
// - Down-scale fill writes zero
// - Diagnostic bit read-only, 1 means bad setup
// - BCD results span both words
// - Channel word 100..400, plus 8000 for binary
// - Each channel converts 270 ms in turn
module tci_input_config #(
   parameter int unsigned CONV_CYCLES = `TCI_CONV_MS * `TCI_CLK_KHZ
) (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   input  wire logic [15:0] fe_value,
   input  wire logic        fe_negative,
   input  wire logic        fe_open,
   output logic      [1:0]  fe_channel,
   output logic      [3:0]  fe_type,
   output logic             fe_scale_celsius,
   output logic             cold_junction_comp,
   output logic             mem_wr,
   output logic      [15:0] mem_addr,
   output logic      [15:0] mem_wdata
);

   // ==========================================================================
   // Configuration registers

   logic [15:0] chan_fmt;
   logic [15:0] result_base_pointer;
   logic [15:0] sensor_type_select;
   logic [15:0] scale_and_sign_format;
   logic [15:0] open_sensor_detect_enable;
   logic [15:0] open_sensor_fill_value;
   logic        setup_error_status;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         chan_fmt                  <= `TCI_RESET_WORD;
         result_base_pointer       <= `TCI_RESET_WORD;
         sensor_type_select        <= `TCI_RESET_WORD;
         scale_and_sign_format     <= `TCI_RESET_WORD;
         open_sensor_detect_enable <= `TCI_RESET_WORD;
         open_sensor_fill_value    <= `TCI_RESET_WORD;
      end else if (reg_wr) begin
         case (reg_addr)
            `TCI_REG_CHAN_FMT: chan_fmt <= reg_wdata;
            `TCI_REG_PTR:      result_base_pointer <= reg_wdata;
            `TCI_REG_TYPE:     sensor_type_select <= reg_wdata;
            `TCI_REG_UNITS:    scale_and_sign_format <= reg_wdata;
            `TCI_REG_OSD_EN:   open_sensor_detect_enable <= reg_wdata;
            `TCI_REG_OSD_FILL: open_sensor_fill_value <= reg_wdata;
            default: begin
            end
         endcase
      end
   end

   // ==========================================================================
   // Setup decode

   logic [3:0] ch_count;
   logic       cfg_ok;
   logic       fmt_bin;
   logic       is_volt;
   logic       pos_only;
   logic       bipolar;
   logic       twos;
   logic       detect_on;

   assign ch_count = chan_fmt[`TCI_CH_CNT_HI:`TCI_CH_CNT_LO];
   // A bad channel, type or units word stops the scan, and the host learns of it only from the diagnostic bit.
   assign cfg_ok   = (ch_count >= `TCI_CH_CNT_MIN) && (ch_count <= `TCI_CH_CNT_MAX)
                     && ((chan_fmt & `TCI_FMT_PAD_MASK) == `TCI_RESET_WORD)
                     && (sensor_type_select <= `TCI_TYPE_LAST)
                     && (scale_and_sign_format <= `TCI_UNITS_LAST);
   assign fmt_bin  = chan_fmt[`TCI_FMT_BIN_BIT];
   assign is_volt  = sensor_type_select > `TCI_TYPE_LAST_TC;
   assign pos_only = (sensor_type_select == `TCI_TYPE_R) || (sensor_type_select == `TCI_TYPE_S)
                     || (sensor_type_select == `TCI_TYPE_B) || (sensor_type_select == `TCI_TYPE_C);
   assign bipolar  = (!is_volt && !pos_only)
                     || (sensor_type_select == `TCI_TYPE_MV39_BI)
                     || (sensor_type_select == `TCI_TYPE_MV78_BI)
                     || (sensor_type_select == `TCI_TYPE_MV156_BI);
   assign twos     = scale_and_sign_format[`TCI_TWOS_BIT];
   // Voltage inputs never take the open-sensor path, the wire cannot be told apart from zero.
   assign detect_on = !is_volt && !open_sensor_detect_enable[`TCI_OSD_BIT];

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         setup_error_status <= 1'b1;
      end else begin
         setup_error_status <= !cfg_ok;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         fe_type            <= 4'h0;
         fe_scale_celsius   <= 1'b0;
         cold_junction_comp <= 1'b0;
      end else begin
         fe_type            <= sensor_type_select[3:0];
         // Scale matters only to thermocouples, results are tenths of a degree.
         fe_scale_celsius   <= !is_volt && scale_and_sign_format[`TCI_SCALE_BIT];
         cold_junction_comp <= !is_volt && cfg_ok;
      end
   end

   // ==========================================================================
   // Register read port, data one cycle after the strobe

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         reg_rdata <= `TCI_RESET_WORD;
      end else if (reg_rd) begin
         case (reg_addr)
            `TCI_REG_CHAN_FMT: reg_rdata <= chan_fmt;
            `TCI_REG_PTR:      reg_rdata <= result_base_pointer;
            `TCI_REG_TYPE:     reg_rdata <= sensor_type_select;
            `TCI_REG_UNITS:    reg_rdata <= scale_and_sign_format;
            `TCI_REG_OSD_EN:   reg_rdata <= open_sensor_detect_enable;
            `TCI_REG_OSD_FILL: reg_rdata <= open_sensor_fill_value;
            `TCI_REG_DIAG:     reg_rdata <= {15'h0000, setup_error_status};
            // Unmapped indices read as zero, so a stray read cannot pass for a setup word.
            default:           reg_rdata <= `TCI_RESET_WORD;
         endcase
      end else begin
         reg_rdata <= `TCI_RESET_WORD;
      end
   end

   // ==========================================================================
   // Result formatting

   function automatic logic [19:0] tci_to_bcd(input logic [15:0] bin);
      logic [35:0] acc;
      acc = {20'h00000, bin};
      for (int i = 0; i < 16; i++) begin
         for (int d = 0; d < 5; d++) begin
            if (acc[16 + 4 * d +: 4] > 4'h4) begin
               acc[16 + 4 * d +: 4] = acc[16 + 4 * d +: 4] + 4'h3;
            end
         end
         acc = {acc[34:0], 1'b0};
      end
      return acc[35:16];
   endfunction

   logic        burn;
   logic [15:0] mag;
   logic        neg;
   logic [19:0] bcd;
   logic [15:0] next_lo;
   logic [15:0] next_hi;

   assign burn = detect_on && fe_open;
   // Bipolar magnitudes clamp at 32767 tenths, unipolar use all 16 bits.
   assign mag  = (bipolar && fe_value > `TCI_UP_BI) ? `TCI_UP_BI : fe_value;
   // Zero magnitude never carries a sign, so minus zero cannot reach the host.
   assign neg  = bipolar && fe_negative && (mag != `TCI_RESET_WORD);
   assign bcd  = tci_to_bcd(mag);

   always_comb begin
      next_lo = mag;
      next_hi = `TCI_RESET_WORD;
      if (burn) begin
         if (open_sensor_fill_value[`TCI_FILL_BIT]) begin
            next_lo = `TCI_DOWN;
         end else begin
            next_lo = bipolar ? `TCI_UP_BI : `TCI_UP_UNI;
         end
      end else if (fmt_bin) begin
         if (neg) begin
            next_lo = twos ? (`TCI_RESET_WORD - mag) : (mag | `TCI_SIGN_MASK);
         end
      end else begin
         // Fifth digit and sign go to the second word of the pair.
         next_lo = bcd[15:0];
         next_hi = {neg, 11'h000, bcd[19:16]};
      end
   end

   // ==========================================================================
   // Scan sequencer

   tci_pkg::tci_state_t state;
   logic [31:0]         timer;
   logic [1:0]          ch;
   logic [15:0]         pend_hi;
   logic                conv_done;
   logic [1:0]          next_ch;
   logic [15:0]         pair_addr;

   assign conv_done = (state == tci_pkg::TCI_CONV) && cfg_ok && (timer == 32'(CONV_CYCLES - 1));
   assign next_ch   = ({2'b00, ch} == ch_count - 4'h1) ? 2'b00 : ch + 2'b01;
   // The pointer is a plain binary word address, and the host does the octal reading.
   assign pair_addr = result_base_pointer + `TCI_PAIR_STRIDE * {14'h0000, ch};

   // A slot cut short by a setup change writes nothing, and the next valid setup starts at channel 1.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state <= tci_pkg::TCI_IDLE;
         timer <= 32'h00000000;
         ch    <= 2'b00;
      end else begin
         case (state)
            tci_pkg::TCI_IDLE: begin
               timer <= 32'h00000000;
               ch    <= 2'b00;
               if (cfg_ok) begin
                  state <= tci_pkg::TCI_CONV;
               end
            end
            tci_pkg::TCI_CONV: begin
               if (!cfg_ok) begin
                  state <= tci_pkg::TCI_IDLE;
               end else if (conv_done) begin
                  // Channels take turns, one conversion slot each.
                  timer <= 32'h00000000;
                  if (!fmt_bin) begin
                     state <= tci_pkg::TCI_SECOND;
                  end else begin
                     ch <= next_ch;
                  end
               end else begin
                  timer <= timer + 32'h00000001;
               end
            end
            tci_pkg::TCI_SECOND: begin
               state <= cfg_ok ? tci_pkg::TCI_CONV : tci_pkg::TCI_IDLE;
               ch    <= next_ch;
            end
            default: begin
               state <= tci_pkg::TCI_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         fe_channel <= 2'b00;
      end else begin
         fe_channel <= ch;
      end
   end

   // ==========================================================================
   // Host memory write port

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mem_wr    <= 1'b0;
         mem_addr  <= `TCI_RESET_WORD;
         mem_wdata <= `TCI_RESET_WORD;
         pend_hi   <= `TCI_RESET_WORD;
      end else begin
         mem_wr <= 1'b0;
         if (conv_done) begin
            mem_wr    <= 1'b1;
            mem_addr  <= pair_addr;
            mem_wdata <= next_lo;
            pend_hi   <= next_hi;
         end else if (state == tci_pkg::TCI_SECOND && cfg_ok) begin
            // A pending second word is dropped once the setup turns bad.
            mem_wr    <= 1'b1;
            mem_addr  <= pair_addr + `TCI_SECOND_WORD;
            mem_wdata <= pend_hi;
         end
      end
   end

   // ==========================================================================
   // Checks

   default clocking tci_cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   sequence s_one_word;
      mem_wr ##1 !mem_wr;
   endsequence

   sequence s_two_words;
      mem_wr ##1 (!$past(cfg_ok) || (mem_wr && mem_addr == $past(mem_addr) + `TCI_SECOND_WORD));
   endsequence

   a_pair_base_addr: assert property (conv_done |=> mem_addr == $past(pair_addr))
      else $error("Result pair base address is wrong.");

   a_binary_one_word: assert property (conv_done && fmt_bin |=> s_one_word)
      else $error("Binary result wrote more than one word.");

   a_bcd_two_words: assert property (conv_done && !fmt_bin |=> s_two_words)
      else $error("BCD result did not fill both words.");

   a_comp_off_volt: assert property (is_volt |=> !cold_junction_comp)
      else $error("Cold junction compensation left on for a voltage input.");

   a_scale_ignored: assert property (is_volt |=> !fe_scale_celsius)
      else $error("Scale bit used for a voltage input.");

   a_fill_up_scale: assert property (conv_done && burn && !open_sensor_fill_value[`TCI_FILL_BIT]
      |=> mem_wdata == ($past(bipolar) ? `TCI_UP_BI : `TCI_UP_UNI))
      else $error("Up-scale fill value is wrong.");

   a_fill_down_scale: assert property (conv_done && burn && open_sensor_fill_value[`TCI_FILL_BIT]
      |=> mem_wdata == `TCI_DOWN)
      else $error("Down-scale fill value is not zero.");

   a_bad_setup_quiet: assert property (!cfg_ok |=> !mem_wr ##1 setup_error_status || cfg_ok)
      else $error("Result written under a bad setup.");

   a_pos_only_plain: assert property (conv_done && pos_only && !burn && fmt_bin
      |=> mem_wdata == $past(fe_value))
      else $error("Positive-only result altered by the sign format.");

   a_negative_msb: assert property (conv_done && fmt_bin && !burn && bipolar && fe_negative
      && fe_value != `TCI_RESET_WORD |=> mem_wdata[15])
      else $error("Negative result lacks its sign bit.");

   a_volt_no_fill: assert property (conv_done && is_volt && fmt_bin && !bipolar
      |=> mem_wdata == $past(fe_value))
      else $error("Voltage result replaced by a fill value.");

   // The channel counter steps once per binary result and wraps after the last enabled channel.
   a_channel_step: assert property (conv_done && fmt_bin && ({2'b00, ch} != ch_count - 4'h1)
      |=> ch == $past(ch) + 2'b01)
      else $error("Channel did not advance after a result.");

   a_channel_wrap: assert property (conv_done && fmt_bin && ({2'b00, ch} == ch_count - 4'h1)
      |=> ch == 2'b00)
      else $error("Channel did not wrap after the last enabled channel.");

   a_diag_read_back: assert property (reg_rd && reg_addr == `TCI_REG_DIAG
      |=> reg_rdata == {15'h0000, $past(setup_error_status)})
      else $error("Diagnostic read does not show the setup status.");

   a_comp_bad_setup: assert property (!cfg_ok |=> !cold_junction_comp)
      else $error("Cold junction compensation left on under a bad setup.");

   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == `TCI_RESET_WORD)
      else $error("Read data did not return to zero after the read cycle.");

endmodule
`default_nettype wire

//--- tci_host_model.sv
// Host memory and sensor front end model facing the thermocouple input block.
`timescale 1ns/1ps
`default_nettype none

module tci_host_model (
   input  wire logic        sys_clk,
   input  wire logic        mem_clear,
   input  wire logic [1:0]  fe_channel,
   input  wire logic        mem_wr,
   input  wire logic [15:0] mem_addr,
   input  wire logic [15:0] mem_wdata,
   input  wire logic [15:0] base_val,
   input  wire logic        neg_in,
   input  wire logic        open_in,
   output logic      [15:0] fe_value,
   output logic             fe_negative,
   output logic             fe_open
);
   // ==========================================================================
   // Front end.
   logic [15:0] mem [0:255];

   // Each channel reads one count above the previous, so a misplaced result is visible.
   assign fe_value    = base_val + {14'h0000, fe_channel};
   assign fe_negative = neg_in;
   assign fe_open     = open_in;

   // ==========================================================================
   // Host memory, a free block of words behind the pointer.
   always_ff @(posedge sys_clk) begin
      if (mem_clear) begin
         // Every word starts at a marker value, so a missing write stands out.
         for (int i = 0; i < 256; i++) begin
            mem[i] <= 16'h5a5a;
         end
      end else if (mem_wr) begin
         mem[mem_addr[7:0]] <= mem_wdata;
      end
   end
endmodule
`default_nettype wire

//--- tci_input_config_bench.sv
// Self-checking testbench for the thermocouple input block.
`timescale 1ns/1ps
`default_nettype none

module tci_input_config_bench;
   logic        sys_clk;
   logic        rst;
   logic [3:0]  reg_addr;
   logic [15:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [15:0] reg_rdata;
   logic [15:0] fe_value;
   logic        fe_negative;
   logic        fe_open;
   logic [1:0]  fe_channel;
   logic [3:0]  fe_type;
   logic        fe_scale_celsius;
   logic        cold_junction_comp;
   logic        mem_wr;
   logic [15:0] mem_addr;
   logic [15:0] mem_wdata;
   logic [15:0] base_val;
   logic        neg_in;
   logic        open_in;
   logic        mem_clear;
   int          n_mismatch;
   int          compares;

   // ==========================================================================
   // Clock, design and model.
   initial sys_clk = 1'b0;
   always #50 sys_clk = ~sys_clk;

   tci_input_config #(.CONV_CYCLES(8)) dut_u (
      .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fe_value(fe_value),
      .fe_negative(fe_negative), .fe_open(fe_open), .fe_channel(fe_channel),
      .fe_type(fe_type), .fe_scale_celsius(fe_scale_celsius),
      .cold_junction_comp(cold_junction_comp), .mem_wr(mem_wr), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata));

   tci_host_model fm_u (
      .sys_clk(sys_clk), .mem_clear(mem_clear), .fe_channel(fe_channel), .mem_wr(mem_wr),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .base_val(base_val), .neg_in(neg_in), .open_in(open_in),
      .fe_value(fe_value), .fe_negative(fe_negative), .fe_open(fe_open));

   // ==========================================================================
   // Tasks.
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so they are sampled there.
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge sys_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      #1;
      chk(reg_rdata, e);
   endtask

   // The channel word goes last, so no result is made with a half-written setup.
   task automatic run_case(input logic [15:0] cf, input logic [15:0] ty, input logic [15:0] un,
                           input logic [15:0] en, input logic [15:0] fl, input logic [15:0] v,
                           input logic ng, input logic op, input logic [15:0] e0,
                           input logic [15:0] e1);
      wr(4'h0, 16'h0000);
      wr(4'h3, ty);
      wr(4'h4, un);
      wr(4'h5, en);
      wr(4'h6, fl);
      base_val <= v;
      neg_in   <= ng;
      open_in  <= op;
      mem_clear <= 1'b1;
      @(posedge sys_clk);
      mem_clear <= 1'b0;
      wr(4'h0, cf);
      repeat (40) @(posedge sys_clk);
      chk(fm_u.mem[64], e0);
      chk(fm_u.mem[65], e1);
   endtask

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // ==========================================================================
   // Watchdog, far beyond the roughly 1140 cycles the tests need.
   initial begin
      repeat (20000) @(posedge sys_clk);
      n_mismatch++;
      give_verdict();
   end

   // ==========================================================================
   // Tests.
   initial begin
      n_mismatch = 0;
      compares   = 0;
      rst        = 1'b1;
      reg_addr   = 4'h0;
      reg_wdata  = 16'h0000;
      reg_wr     = 1'b0;
      reg_rd     = 1'b0;
      base_val   = 16'h0000;
      neg_in     = 1'b0;
      open_in    = 1'b0;
      mem_clear  = 1'b0;
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      rd(4'h7, 16'h0001);
      rd(4'h2, 16'h0000);
      wr(4'h1, 16'h0040);
      rd(4'h1, 16'h0040);
      wr(4'h3, 16'h000e);
      rd(4'h3, 16'h000e);
      wr(4'h4, 16'h0003);
      rd(4'h4, 16'h0003);
      wr(4'h5, 16'h0001);
      rd(4'h5, 16'h0001);
      wr(4'h6, 16'h0001);
      rd(4'h6, 16'h0001);
      rd(4'h0, 16'h0000);
      $display("test registers done");
      run_case(16'h8200, 16'h0, 16'h1, 16'h0, 16'h0, 16'h64, 1'b0, 1'b0, 16'h64, 16'h5a5a);
      chk(fm_u.mem[66], 16'h0065);
      rd(4'h7, 16'h0000);
      run_case(16'h8200, 16'h0, 16'h3, 16'h0, 16'h0, 16'h64, 1'b1, 1'b0, 16'hff9c, 16'h5a5a);
      run_case(16'h8200, 16'h0, 16'h0, 16'h0, 16'h0, 16'h64, 1'b1, 1'b0, 16'h8064, 16'h5a5a);
      run_case(16'h8200, 16'h0, 16'h0, 16'h0, 16'h0, 16'hf000, 1'b0, 1'b0, 16'h7fff, 16'h5a5a);
      run_case(16'h8200, 16'h3, 16'h0, 16'h0, 16'h0, 16'hf000, 1'b0, 1'b0, 16'hf000, 16'h5a5a);
      run_case(16'h8200, 16'h3, 16'h3, 16'h0, 16'h0, 16'h1388, 1'b1, 1'b0, 16'h1388, 16'h5a5a);
      run_case(16'h8200, 16'ha, 16'h3, 16'h0, 16'h0, 16'h64, 1'b1, 1'b0, 16'hff9c, 16'h5a5a);
      run_case(16'h8200, 16'ha, 16'h0, 16'h0, 16'h0, 16'h64, 1'b1, 1'b0, 16'h8064, 16'h5a5a);
      run_case(16'h8200, 16'h0, 16'h1, 16'h0, 16'h0, 16'h64, 1'b0, 1'b1, 16'h7fff, 16'h5a5a);
      run_case(16'h8200, 16'h3, 16'h1, 16'h0, 16'h0, 16'h64, 1'b0, 1'b1, 16'hffff, 16'h5a5a);
      run_case(16'h8200, 16'h0, 16'h1, 16'h0, 16'h1, 16'h64, 1'b0, 1'b1, 16'h0000, 16'h5a5a);
      run_case(16'h8200, 16'h0, 16'h1, 16'h1, 16'h0, 16'h64, 1'b0, 1'b1, 16'h0064, 16'h5a5a);
      run_case(16'h8200, 16'ha, 16'h1, 16'h0, 16'h0, 16'h64, 1'b0, 1'b1, 16'h0064, 16'h5a5a);
      run_case(16'h8200, 16'he, 16'h1, 16'h0, 16'h0, 16'hf000, 1'b0, 1'b1, 16'hf000, 16'h5a5a);
      run_case(16'h0100, 16'h0, 16'h1, 16'h0, 16'h0, 16'h3039, 1'b0, 1'b0, 16'h2345, 16'h0001);
      run_case(16'h0100, 16'h0, 16'h1, 16'h0, 16'h0, 16'h3039, 1'b1, 1'b0, 16'h2345, 16'h8001);
      run_case(16'h8200, 16'hf, 16'h1, 16'h0, 16'h0, 16'h64, 1'b0, 1'b0, 16'h5a5a, 16'h5a5a);
      run_case(16'h8500, 16'h0, 16'h1, 16'h0, 16'h0, 16'h64, 1'b0, 1'b0, 16'h5a5a, 16'h5a5a);
      run_case(16'h8200, 16'h0, 16'h4, 16'h0, 16'h0, 16'h64, 1'b0, 1'b0, 16'h5a5a, 16'h5a5a);
      chk({15'h0000, cold_junction_comp}, 16'h0000);
      wr(4'h7, 16'h0000);
      rd(4'h7, 16'h0001);
      $display("test results done");
      wr(4'h4, 16'h0001);
      wr(4'h0, 16'h8100);
      for (int t = 0; t < 15; t++) begin
         wr(4'h3, 16'(t));
         repeat (3) @(posedge sys_clk);
         chk({12'h000, fe_type}, 16'(t));
         chk({15'h0000, cold_junction_comp}, {15'h0000, (t < 9)});
         chk({15'h0000, fe_scale_celsius}, {15'h0000, (t < 9)});
      end
      $display("test types done");
      give_verdict();
   end
endmodule
`default_nettype wire
